// ### include/twb_defines.vh
`ifndef TWB_DEFINES_VH
`define TWB_DEFINES_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define TWB_REG_CTRL 8'h00
`define TWB_REG_DATA 8'h01
`define TWB_REG_SADR 8'h02
`define TWB_REG_GIE 8'h20

// ------------------------------------------------------------
// Status and control fields
// ------------------------------------------------------------
`define TWB_B_EN 0
`define TWB_B_STOP 1
`define TWB_B_ARB 2
`define TWB_B_ADDR 3
`define TWB_B_ACK 4
`define TWB_B_XMIT 5
`define TWB_B_BUSY 6
`define TWB_B_MSTR 7
`define TWB_B_GIE_TWB 6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define TWB_RST_CTRL 8'h00
`define TWB_RST_GIE 8'h00
`define TWB_RST_SADR 7'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define TWB_CLK_MHZ 100
`define TWB_HALF_NS 5000
// Half bus clock in system cycles: 5000 ns at 100 MHz, sized for the 16-bit counter
`define TWB_HALF_CYC 16'h01f4

`endif

// ### hdl/twb_sync.v
`timescale 1ns/1ps
`default_nettype none

module twb_sync #(
	parameter W = 2
) (
	// Clock and reset
	input wire i_ref_clk,
	input wire i_rst,
	// Asynchronous in, synchronous out
	input wire [W-1:0] i_async,
	output wire [W-1:0] o_sync
);

	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// Idle bus lines are high, so reset to ones to avoid a false edge
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			meta_ff <= {W{1'b1}};
			sync_ff <= {W{1'b1}};
		end
		else
		begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;

endmodule // twb_sync

`default_nettype wire

// ### hdl/twb_ctrl.v
// Overview of operation
// - Enable bit 0 hands both pins to the bus function, open drain.
// - Stop flag sets only in slave receive, and only if the last byte was acked.
// - Arbitration loss clears master select, sets bit 2, raises an interrupt.
// - Bit 2 with continue and master select does a restart; hardware clears bit 2.
// - First-byte flag reads 1 after slave start or arbitration loss; continue clears it.
// - In receive, ack bit 1 pulls data low in the ack slot; 0 leaves it high.
// - In transmit, ack bit reads back the acknowledge from the receiver.
// - Bit 5 picks transmit or receive; first master byte after start or restart always transmits; a slave receives its first byte.
// - Continue releases the next byte; busy reads 1 until the byte completes.
// - Control writes are ignored while busy.
// - After an interrupt the block stays idle until firmware sets continue or clears master select.
// - Setting master select issues start then sends the data register.
// - Later master bytes start only on continue.
// - Master drives clock and data, arbitrates and follows clock stretching.
// - Clearing master select from 1 to 0 sends a stop.
// - If addressed after losing arbitration, the interrupt waits for the transfer end.
// - The interrupt reaches the processor only with enable bit 6 set.
`timescale 1ns/1ps
`default_nettype none
`include "twb_defines.vh"

module twb_ctrl #(
	parameter [15:0] HALF_CYC = `TWB_HALF_CYC
) (
	// Clock and reset
	input wire i_ref_clk,
	input wire i_rst,
	// Register port
	input wire [7:0] i_addr,
	input wire [7:0] i_wdata,
	input wire i_wr_en,
	input wire i_rd_en,
	output wire [7:0] o_rdata,
	// Interrupt
	output wire o_irq,
	// Bus pins
	input wire i_scl_i,
	output wire o_scl_o,
	output wire o_scl_oe,
	input wire i_sda_i,
	output wire o_sda_o,
	output wire o_sda_oe,
	// Port logic driving the pins when the bus function is off
	input wire i_gpio_scl_o,
	input wire i_gpio_scl_oe,
	input wire i_gpio_sda_o,
	input wire i_gpio_sda_oe
);

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_MSTART = 4'h1;
	localparam [3:0] ST_MLO = 4'h2;
	localparam [3:0] ST_MHI = 4'h3;
	localparam [3:0] ST_MWAIT = 4'h4;
	localparam [3:0] ST_MSTOP = 4'h5;
	localparam [3:0] ST_MRST = 4'h6;
	localparam [3:0] ST_SLV = 4'h7;
	localparam [3:0] ST_SWAIT = 4'h8;
	localparam [15:0] QUART_CYC = HALF_CYC >> 1;

	reg [3:0] state_ff;
	reg [1:0] ph_ff;
	reg [15:0] cnt_ff;
	reg [3:0] bit_ff;
	reg [7:0] shift_ff;
	reg [7:0] data_ff;
	reg [7:0] gie_ff;
	reg [6:0] sadr_ff;
	reg [7:0] rdata_ff;
	reg en_ff, stop_ff, arb_ff, addr_ff, ack_wr_ff, ack_rx_ff, xmit_ff, busy_ff, mstr_ff;
	reg tx_ff, first_ff, defer_ff, last_ack_ff, irq_pend_ff, bus_busy_ff;
	reg scl_low_ff, sda_low_ff, scl_prev_ff, sda_prev_ff;

	wire [1:0] pin_s;
	wire scl_s = pin_s[1];
	wire sda_s = pin_s[0];

	twb_sync #(
		.W(2)
	) u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_async({i_scl_i, i_sda_i}),
		.o_sync(pin_s)
	);

	// ------------------------------------------------------------
	// Bus events and register decode
	// ------------------------------------------------------------
	wire scl_rise = scl_s & ~scl_prev_ff;
	wire scl_fall = ~scl_s & scl_prev_ff;
	wire start_det = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
	wire stop_det = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
	wire wr_ctrl = i_wr_en & (i_addr == `TWB_REG_CTRL) & ~busy_ff;
	wire [7:0] w = i_wdata;
	wire cnt_done = (cnt_ff == 16'h0000);
	wire ack_rd = tx_ff ? ack_rx_ff : ack_wr_ff;
	wire [7:0] ctrl_rd = {mstr_ff, busy_ff, xmit_ff, ack_rd, addr_ff, arb_ff, stop_ff, en_ff};

	// Whether the master pulls the data line low for bit n of the byte
	function drive_low;
		input [3:0] n;
		input tx;
		input msb;
		input ack;
		begin
			drive_low = (n < 4'h8) ? (tx & ~msb) : (~tx & ack);
		end
	endfunction

	// ------------------------------------------------------------
	// Main sequencer
	// ------------------------------------------------------------
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_ff <= ST_IDLE;
			ph_ff <= 2'h0;
			cnt_ff <= 16'h0000;
			bit_ff <= 4'h0;
			shift_ff <= 8'h00;
			data_ff <= 8'h00;
			gie_ff <= `TWB_RST_GIE;
			sadr_ff <= `TWB_RST_SADR;
			{mstr_ff, busy_ff, xmit_ff, ack_wr_ff, addr_ff, arb_ff, stop_ff, en_ff} <= `TWB_RST_CTRL;
			ack_rx_ff <= 1'b0;
			tx_ff <= 1'b0;
			first_ff <= 1'b0;
			defer_ff <= 1'b0;
			last_ack_ff <= 1'b0;
			irq_pend_ff <= 1'b0;
			bus_busy_ff <= 1'b0;
			scl_low_ff <= 1'b0;
			sda_low_ff <= 1'b0;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end
		else
		begin
			scl_prev_ff <= scl_s;
			sda_prev_ff <= sda_s;
			if (start_det)
				bus_busy_ff <= 1'b1;
			if (stop_det)
				bus_busy_ff <= 1'b0;
			if (cnt_ff != 16'h0000)
				cnt_ff <= cnt_ff - 16'h0001;
			if (i_wr_en && i_addr == `TWB_REG_DATA)
				data_ff <= w;
			if (i_wr_en && i_addr == `TWB_REG_GIE)
				gie_ff <= w;
			if (i_wr_en && i_addr == `TWB_REG_SADR)
				sadr_ff <= w[6:0];
			// Event flags are written before the sequencer so a hardware set wins
			if (wr_ctrl)
			begin
				en_ff <= w[`TWB_B_EN];
				stop_ff <= stop_ff & w[`TWB_B_STOP];
				arb_ff <= w[`TWB_B_ARB];
				ack_wr_ff <= w[`TWB_B_ACK];
				xmit_ff <= w[`TWB_B_XMIT];
				mstr_ff <= w[`TWB_B_MSTR];
				if (w[`TWB_B_BUSY])
				begin
					addr_ff <= 1'b0;
					irq_pend_ff <= 1'b0;
				end
			end
			case (state_ff)
				ST_IDLE:
				begin
					if (wr_ctrl && w[`TWB_B_MSTR] && !mstr_ff && w[`TWB_B_EN])
					begin
						busy_ff <= 1'b1;
						tx_ff <= 1'b1;
						shift_ff <= data_ff;
						first_ff <= 1'b1;
						ph_ff <= 2'h0;
						state_ff <= ST_MSTART;
					end
					else if (en_ff && start_det)
					begin
						state_ff <= ST_SLV;
						bit_ff <= 4'h0;
						tx_ff <= 1'b0;
						first_ff <= 1'b1;
						last_ack_ff <= 1'b0;
						addr_ff <= 1'b1;
					end
				end
				ST_MSTART:
				begin
					if (ph_ff == 2'h0 && !bus_busy_ff)
					begin
						sda_low_ff <= 1'b1;
						cnt_ff <= HALF_CYC;
						ph_ff <= 2'h1;
					end
					else if (ph_ff == 2'h1 && cnt_done)
					begin
						scl_low_ff <= 1'b1;
						cnt_ff <= HALF_CYC;
						bit_ff <= 4'h0;
						state_ff <= ST_MLO;
					end
				end
				ST_MLO:
				begin
					if (cnt_ff == QUART_CYC)
						sda_low_ff <= drive_low(bit_ff, tx_ff, shift_ff[7], ack_wr_ff);
					if (cnt_done)
					begin
						scl_low_ff <= 1'b0;
						ph_ff <= 2'h0;
						state_ff <= ST_MHI;
					end
				end
				ST_MHI:
				begin
					// Wait for the wire to go high so a slower master or slave stretches us
					if (ph_ff == 2'h0 && scl_s)
					begin
						cnt_ff <= HALF_CYC;
						ph_ff <= 2'h1;
						if (bit_ff < 4'h8)
							shift_ff <= {shift_ff[6:0], sda_s};
						else if (tx_ff)
							ack_rx_ff <= ~sda_s;
						if (tx_ff && bit_ff < 4'h8 && !sda_low_ff && !sda_s)
						begin
							mstr_ff <= 1'b0;
							arb_ff <= 1'b1;
							addr_ff <= 1'b1;
							irq_pend_ff <= 1'b1;
							busy_ff <= 1'b0;
							defer_ff <= first_ff;
							tx_ff <= 1'b0;
							scl_low_ff <= 1'b0;
							sda_low_ff <= 1'b0;
							state_ff <= first_ff ? ST_SLV : ST_IDLE;
						end
					end
					else if (ph_ff == 2'h1 && (cnt_done || !scl_s))
					begin
						scl_low_ff <= 1'b1;
						if (bit_ff == 4'h8)
						begin
							sda_low_ff <= 1'b0;
							busy_ff <= 1'b0;
							irq_pend_ff <= 1'b1;
							if (!tx_ff)
								data_ff <= shift_ff;
							state_ff <= ST_MWAIT;
						end
						else
						begin
							bit_ff <= bit_ff + 4'h1;
							cnt_ff <= HALF_CYC;
							state_ff <= ST_MLO;
						end
					end
				end
				ST_MWAIT:
				begin
					// Clock held low here until firmware decides what comes next
					if (wr_ctrl && !w[`TWB_B_MSTR])
					begin
						busy_ff <= 1'b1;
						// A stop ends the transfer, so the byte interrupt has been served
						irq_pend_ff <= 1'b0;
						ph_ff <= 2'h0;
						state_ff <= ST_MSTOP;
					end
					else if (wr_ctrl && w[`TWB_B_BUSY] && w[`TWB_B_ARB])
					begin
						busy_ff <= 1'b1;
						tx_ff <= 1'b1;
						shift_ff <= data_ff;
						first_ff <= 1'b1;
						ph_ff <= 2'h0;
						state_ff <= ST_MRST;
					end
					else if (wr_ctrl && w[`TWB_B_BUSY])
					begin
						busy_ff <= 1'b1;
						tx_ff <= w[`TWB_B_XMIT];
						shift_ff <= data_ff;
						first_ff <= 1'b0;
						bit_ff <= 4'h0;
						cnt_ff <= HALF_CYC;
						state_ff <= ST_MLO;
					end
				end
				ST_MRST:
				begin
					if (ph_ff == 2'h0)
					begin
						arb_ff <= 1'b0;
						sda_low_ff <= 1'b0;
						cnt_ff <= HALF_CYC;
						ph_ff <= 2'h1;
					end
					else if (ph_ff == 2'h1 && cnt_done)
					begin
						scl_low_ff <= 1'b0;
						ph_ff <= 2'h2;
					end
					else if (ph_ff == 2'h2 && scl_s)
					begin
						cnt_ff <= HALF_CYC;
						ph_ff <= 2'h3;
					end
					else if (ph_ff == 2'h3 && cnt_done)
					begin
						// Second half of the start is shared with a fresh start
						sda_low_ff <= 1'b1;
						cnt_ff <= HALF_CYC;
						ph_ff <= 2'h1;
						state_ff <= ST_MSTART;
					end
				end
				ST_MSTOP:
				begin
					if (ph_ff == 2'h0)
					begin
						sda_low_ff <= 1'b1;
						cnt_ff <= HALF_CYC;
						ph_ff <= 2'h1;
					end
					else if (ph_ff == 2'h1 && cnt_done)
					begin
						scl_low_ff <= 1'b0;
						ph_ff <= 2'h2;
					end
					else if (ph_ff == 2'h2 && scl_s)
					begin
						cnt_ff <= HALF_CYC;
						ph_ff <= 2'h3;
					end
					else if (ph_ff == 2'h3 && cnt_done)
					begin
						sda_low_ff <= 1'b0;
						busy_ff <= 1'b0;
						state_ff <= ST_IDLE;
					end
				end
				ST_SLV:
				begin
					if (scl_rise)
					begin
						if (bit_ff < 4'h8)
							shift_ff <= {shift_ff[6:0], sda_s};
						else if (tx_ff)
							ack_rx_ff <= ~sda_s;
					end
					else if (scl_fall && bit_ff == 4'h7)
					begin
						bit_ff <= 4'h8;
						sda_low_ff <= 1'b0;
						if (first_ff && shift_ff[7:1] != sadr_ff)
						begin
							defer_ff <= 1'b0;
							state_ff <= ST_IDLE;
						end
						else if (!defer_ff && !tx_ff)
						begin
							// Stretch before the ack slot so firmware picks the ack
							scl_low_ff <= 1'b1;
							busy_ff <= 1'b0;
							irq_pend_ff <= 1'b1;
							data_ff <= shift_ff;
							state_ff <= ST_SWAIT;
						end
					end
					else if (scl_fall && bit_ff == 4'h8 && tx_ff && !defer_ff)
					begin
						scl_low_ff <= 1'b1;
						busy_ff <= 1'b0;
						irq_pend_ff <= 1'b1;
						state_ff <= ST_SWAIT;
					end
					else if (scl_fall)
					begin
						bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
						sda_low_ff <= tx_ff & ~shift_ff[7];
					end
				end
				ST_SWAIT:
				begin
					if (wr_ctrl && w[`TWB_B_BUSY])
					begin
						busy_ff <= 1'b1;
						first_ff <= 1'b0;
						scl_low_ff <= 1'b0;
						state_ff <= ST_SLV;
						if (!tx_ff)
						begin
							sda_low_ff <= w[`TWB_B_ACK];
							last_ack_ff <= w[`TWB_B_ACK];
							tx_ff <= w[`TWB_B_XMIT];
							shift_ff <= data_ff;
						end
						else
						begin
							bit_ff <= 4'h0;
							tx_ff <= w[`TWB_B_XMIT];
							shift_ff <= data_ff;
							sda_low_ff <= w[`TWB_B_XMIT] & ~data_ff[7];
						end
					end
				end
				default:
					state_ff <= ST_IDLE;
			endcase
			if ((state_ff == ST_SLV || state_ff == ST_SWAIT) && stop_det)
			begin
				if (!tx_ff && last_ack_ff)
					stop_ff <= 1'b1;
				defer_ff <= 1'b0;
				busy_ff <= 1'b0;
				scl_low_ff <= 1'b0;
				sda_low_ff <= 1'b0;
				state_ff <= ST_IDLE;
			end
			// The write that sets enable must not be undone by the old enable value
			if (wr_ctrl ? !w[`TWB_B_EN] : !en_ff)
			begin
				scl_low_ff <= 1'b0;
				sda_low_ff <= 1'b0;
				busy_ff <= 1'b0;
				state_ff <= ST_IDLE;
			end
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	always @(posedge i_ref_clk or posedge i_rst)
	begin
		if (i_rst)
			rdata_ff <= 8'h00;
		else if (!i_rd_en)
			rdata_ff <= 8'h00;
		else
			case (i_addr)
				`TWB_REG_CTRL: rdata_ff <= ctrl_rd;
				`TWB_REG_DATA: rdata_ff <= data_ff;
				`TWB_REG_SADR: rdata_ff <= {1'b0, sadr_ff};
				`TWB_REG_GIE: rdata_ff <= gie_ff;
				default: rdata_ff <= 8'h00;
			endcase
	end

	assign o_rdata = rdata_ff;
	assign o_irq = irq_pend_ff & gie_ff[`TWB_B_GIE_TWB] & ~defer_ff;

	// Open drain: only ever drive low, otherwise hand the pins to the port logic
	assign o_scl_o = en_ff ? 1'b0 : i_gpio_scl_o;
	assign o_scl_oe = en_ff ? scl_low_ff : i_gpio_scl_oe;
	assign o_sda_o = en_ff ? 1'b0 : i_gpio_sda_o;
	assign o_sda_oe = en_ff ? sda_low_ff : i_gpio_sda_oe;

endmodule // twb_ctrl

`default_nettype wire

// ### dv/twb_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module twb_monitor (
	// Clock, reset and register port
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire logic [7:0] o_rdata,
	input wire logic o_irq,
	// Pins
	input wire logic o_scl_o,
	input wire logic o_scl_oe,
	input wire logic o_sda_o,
	input wire logic o_sda_oe,
	input wire logic i_gpio_scl_o,
	input wire logic i_gpio_scl_oe,
	input wire logic i_gpio_sda_o,
	input wire logic i_gpio_sda_oe
);
	logic gie_ff;
	logic ctl_wr;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	assign ctl_wr = i_wr_en && i_addr == 8'h00;
	// Shadow of the enable bit; the interrupt flop may lag it by a cycle
	always_ff @(posedge i_ref_clk or posedge i_rst)
		if (i_rst)
			gie_ff <= 1'b0;
		else if (i_wr_en && i_addr == 8'h20)
			gie_ff <= i_wdata[6];

	a_sda_open_drain: assert property (o_sda_oe && o_sda_o |-> i_gpio_sda_oe && i_gpio_sda_o)
		else $error("data pin driven high by bus function");
	a_scl_open_drain: assert property (o_scl_oe && o_scl_o |-> i_gpio_scl_oe && i_gpio_scl_o)
		else $error("clock pin driven high by bus function");
	a_irq_gated: assert property (o_irq |-> gie_ff || $past(gie_ff))
		else $error("interrupt shown while disabled");
	a_irq_holds: assert property (o_irq && !i_wr_en |=> o_irq)
		else $error("interrupt dropped without a write");
	a_irq_clears: assert property (o_irq && ctl_wr && (i_wdata[6] || !i_wdata[7]) |=> !o_irq)
		else $error("interrupt not cleared by continue or stop");
	a_idle_after_irq: assert property (i_rd_en && i_addr == 8'h00 && o_irq |=> !o_rdata[6])
		else $error("busy read while interrupt pending");
	a_rdata_idle: assert property (!$past(i_rd_en) |-> o_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_scl_low_min: assert property ($rose(o_scl_oe) && !o_scl_o |-> o_scl_oe [*4])
		else $error("clock low phase too short");
	a_start_hold: assert property ($rose(o_sda_oe) && !o_sda_o && !o_scl_oe |-> !o_scl_oe [*4])
		else $error("clock pulled too soon after start");

	c_irq: cover property ($rose(o_irq));
	c_stop: cover property (o_irq && ctl_wr && !i_wdata[7]);
	c_start: cover property ($rose(o_sda_oe) && !o_scl_oe && !o_sda_o);
endmodule // twb_monitor

bind twb_ctrl twb_monitor u_mon (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
	.i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rdata(o_rdata), .o_irq(o_irq), .o_scl_o(o_scl_o),
	.o_scl_oe(o_scl_oe), .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .i_gpio_scl_o(i_gpio_scl_o),
	.i_gpio_scl_oe(i_gpio_scl_oe), .i_gpio_sda_o(i_gpio_sda_o), .i_gpio_sda_oe(i_gpio_sda_oe));

`default_nettype wire

// ### dv/twb_bus_model.sv
`timescale 1ns/1ps
`default_nettype none

module twb_bus_model (
	// Wire levels and behaviour select
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_ack_en,
	// Pull on the data line
	output logic o_sda_low
);
	int bit_cnt;
	initial
	begin
		o_sda_low = 1'b0;
		bit_cnt = 0;
	end
	// A start or repeated start frames a fresh byte
	always @(negedge i_sda)
		if (i_scl === 1'b1)
			bit_cnt = 0;
	always @(posedge i_scl)
		bit_cnt = bit_cnt + 1;
	// Ack slot opens after the eighth clock and closes after the ninth
	always @(negedge i_scl)
	begin
		o_sda_low = (bit_cnt == 8) && i_ack_en;
		if (bit_cnt >= 9)
			bit_cnt = 0;
	end
endmodule // twb_bus_model

`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "twb_defines.vh"

module tb_top;
	logic ref_clk;
	logic rst;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr_en;
	logic rd_en;
	logic [7:0] rdata;
	logic irq;
	logic scl_o, scl_oe, sda_o, sda_oe;
	logic g_sda_o, g_sda_oe;
	logic ack_en, grab, sda_low;
	logic [7:0] d;
	logic sda_at_rise;
	wire logic scl_w, sda_w;
	int error_cnt, n_tests;

	// Pull-ups: a released line reads high
	assign scl_w = scl_oe ? scl_o : 1'b1;
	assign sda_w = (sda_oe ? sda_o : 1'b1) & !sda_low & !grab;

	twb_ctrl #(.HALF_CYC(16'h0008)) dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr_en(wr_en), .i_rd_en(rd_en), .o_rdata(rdata), .o_irq(irq), .i_scl_i(scl_w), .o_scl_o(scl_o),
		.o_scl_oe(scl_oe), .i_sda_i(sda_w), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_gpio_scl_o(1'b1),
		.i_gpio_scl_oe(1'b0), .i_gpio_sda_o(g_sda_o), .i_gpio_sda_oe(g_sda_oe));
	twb_bus_model u_model (.i_scl(scl_w), .i_sda(sda_w), .i_ack_en(ack_en), .o_sda_low(sda_low));

	// Data level at the latest clock rise; after a byte this is the ack slot
	always @(posedge scl_w)
		sda_at_rise <= sda_w;

	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// ------------------------------------------------------------
	// Register access and checking
	// ------------------------------------------------------------
	task automatic give_verdict;
		if (error_cnt == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask

	// An idle edge after each write keeps strobes from being set twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		@(negedge ref_clk);
		v = rdata;
		@(posedge ref_clk);
	endtask

	task automatic wait_idle;
		for (int i = 0; i < 400; i++)
		begin
			rd(`TWB_REG_CTRL, d);
			if (d[6] === 1'b0)
				return;
		end
		error_cnt++;
		give_verdict();
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		g_sda_o = 1'b1;
		g_sda_oe = 1'b1;
		ack_en = 1'b1;
		grab = 1'b0;
		error_cnt = 0;
		n_tests = 0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		rd(`TWB_REG_CTRL, d);
		chk(d, `TWB_RST_CTRL);
		rd(`TWB_REG_GIE, d);
		chk(d, `TWB_RST_GIE);
		chk({6'h00, sda_oe, sda_o}, 8'h03);
		g_sda_oe <= 1'b0;
		wr(8'h10, 8'hff);
		rd(8'h10, d);
		chk(d, 8'h00);
		// Address byte as master, acknowledged
		wr(`TWB_REG_GIE, 8'h40);
		wr(`TWB_REG_DATA, 8'ha4);
		wr(`TWB_REG_CTRL, 8'h81);
		rd(`TWB_REG_CTRL, d);
		chk(d & 8'hc1, 8'hc1);
		wr(`TWB_REG_CTRL, 8'h00);
		wait_idle();
		repeat (20) @(posedge ref_clk);
		rd(`TWB_REG_CTRL, d);
		chk(d & 8'hd0, 8'h90);
		chk({7'h00, irq}, 8'h01);
		// Second byte refused by the far side
		ack_en <= 1'b0;
		wr(`TWB_REG_DATA, 8'h5a);
		wr(`TWB_REG_CTRL, 8'he1);
		chk({7'h00, irq}, 8'h00);
		wait_idle();
		chk(d & 8'h10, 8'h00);
		// Repeated start with the interrupt masked
		ack_en <= 1'b1;
		wr(`TWB_REG_GIE, 8'h00);
		wr(`TWB_REG_DATA, 8'ha5);
		wr(`TWB_REG_CTRL, 8'he5);
		wait_idle();
		chk(d & 8'h94, 8'h90);
		chk({7'h00, irq}, 8'h00);
		// One byte received and acknowledged by us, far side silent in the ack slot
		ack_en <= 1'b0;
		wr(`TWB_REG_CTRL, 8'hd1);
		wait_idle();
		chk(d & 8'hb0, 8'h90);
		chk({7'h00, sda_at_rise}, 8'h00);
		rd(`TWB_REG_DATA, d);
		chk(d, 8'hff);
		// Stop by dropping master select
		wr(`TWB_REG_GIE, 8'h40);
		wr(`TWB_REG_CTRL, 8'h01);
		wait_idle();
		chk(d & 8'h81, 8'h01);
		chk({5'h00, scl_w, sda_w, irq}, 8'h06);
		// Another master holds data low during our first bit
		wr(`TWB_REG_DATA, 8'hff);
		wr(`TWB_REG_CTRL, 8'h81);
		for (int i = 0; i < 200 && scl_oe !== 1'b1; i++)
			@(posedge ref_clk);
		if (scl_oe !== 1'b1)
		begin
			error_cnt++;
			give_verdict();
		end
		grab <= 1'b1;
		wait_idle();
		chk(d & 8'h8c, 8'h0c);
		grab <= 1'b0;
		give_verdict();
	end
endmodule // tb_top

`default_nettype wire
